// ==== verilog/pmfid_regs.v ====
// feature identification registers: usage monitor capabilities and
// component feature flags, seen through secure and non-secure pages
// assumes: one request per cycle at most, requester on clk_sys, selected
// instance comes from the partition select register on the same clock
//
// Summary of operation
// (R1) capture bit set only with snapshot support
// (R2) counter read-only flag: 1 read-only, 0 writable
// (R3) overflow bitmap bit only on extended architecture
// (R4) bits 15:0 report monitor instance count
// (R5) instance fields follow selected partition instance
// (R6) capability register zero unless monitors and usage
// (R7) capability register read-only at offset 0x88
// (R8) capability register readable from both pages
// (R9) secure page keeps its own differing copy
// (R10) monitor select instance field has no effect
// (R11) feature register 64 bits on extended architecture
// (R12) highest instance field, zero without selection
// (R13) error message-write flag needs error status
// (R14) error status flag reports error registers present
// (R15) wide error status forced with instance selection
// (R16) custom monitor/control absence bits 37, 36
// (R17) instance select flag bit 32 when extended
// (R18) narrowing flag reports narrowing support
// (R19) monitor presence flag bit 30
// (R20) custom feature register flag bit 29
// (R21) extended layout flag marks defined upper half
// (R22) partitioning flags in bits 27 to 24
// (R23) group and partition maxima in low bits
// (R24) writes ignored, reserved bits read zero
// (R25) all values fixed by implementation constants
`timescale 1ns/1ps
`default_nettype none
`include "pmfid_defines.vh"

module pmfid_regs (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        rdReq,
    input  wire        wrReq,
    input  wire        secure,
    input  wire [11:0] addr,
    input  wire [3:0]  selInstance,
    output reg  [31:0] rdData_r,
    output reg         ack_r
);

    // word compare on an aligned byte offset
    function pageHit;
        input [11:0] a;
        input [11:0] off;
        begin
            pageHit = (a[11:2] == off[11:2]);
        end
    endfunction

    reg  [31:0] rdData_nxt;
    reg         ack_nxt;

    wire        archExt;
    wire        extLayout;
    wire        hasRis;
    wire        hasEsr;
    wire        hasErrMsi;
    wire        wideEsr;
    wire        hasImpl;
    wire        hasNrw;
    wire        hasMsmon;
    wire        csuPresent;
    wire [3:0]  instSel;
    wire [3:0]  risMax;
    wire [7:0]  pmgMax;
    wire [15:0] partidMax;

    wire        tInstValid;
    wire        tCapture;
    wire        tCsuRo;
    wire        tOfsr;
    wire [15:0] tNumMon;
    wire [3:0]  tPart;
    wire        tNoMon;
    wire        tNoCtl;

    wire [31:0] csuWord;
    wire [31:0] idrLoWord;
    wire [31:0] idrHiWord;
    wire        hitCsu;
    wire        hitLo;
    wire        hitHi;

    // (R25) fixed identification values
    assign archExt   = `PMFID_CFG_ARCH_EXT;
    assign hasRis    = archExt & `PMFID_CFG_EXT & `PMFID_CFG_RIS;
    assign hasEsr    = archExt & `PMFID_CFG_EXT & `PMFID_CFG_ESR;
    assign hasImpl   = `PMFID_CFG_IMPL;
    assign hasNrw    = `PMFID_CFG_NRW;
    assign hasMsmon  = `PMFID_CFG_MSMON;

    // (R21) extended layout only on extended architecture
    assign extLayout = archExt & `PMFID_CFG_EXT;

    // (R13) message writes need error status
    assign hasErrMsi = hasEsr & `PMFID_CFG_ERRMSI;

    // (R15) wide status forced with instance selection
    assign wideEsr   = hasEsr & (`PMFID_CFG_EXTDESR | hasRis);

    // (R12) highest instance zero without selection
    assign risMax    = hasRis ? `PMFID_CFG_HIGHEST_INSTANCE_NUMBER : 4'h0;

    // (R6) usage monitoring must be indicated
    assign csuPresent = hasMsmon & `PMFID_CFG_CSU;

    // (R5) track the instance chosen by partition select
    // (R10) the monitor select instance field is not an input at all
    assign instSel = hasRis ? selInstance : 4'h0;

    // (R9) secure page carries its own maxima
    assign pmgMax    = secure ? `PMFID_CFG_PMG_S : `PMFID_CFG_PMG_NS;
    assign partidMax = secure ? `PMFID_CFG_PARTITION_IDENTIFIER_S : `PMFID_CFG_PARTITION_IDENTIFIER_NS;

    // (R9) per instance counts split by page
    pmfid_inst_table u_table (
        .instSel   (instSel),
        .secure    (secure),
        .instValid (tInstValid),
        .capture   (tCapture),
        .csuRo     (tCsuRo),
        .ofsr      (tOfsr),
        .numMon    (tNumMon),
        .partFlags (tPart),
        .noMon     (tNoMon),
        .noCtl     (tNoCtl)
    );

    // usage monitor capability word
    reg [31:0] csuBuild;
    always @* begin
        csuBuild = 32'h00000000;
        // (R1) capture with snapshot only
        csuBuild[`PMFID_CSU_CAPTURE] = tCapture;
        // (R2) counter read-only flag
        csuBuild[`PMFID_USAGE_COUNTER_READONLY_FLAG] = tCsuRo;
        // (R3) bitmap bit reserved off extended architecture
        csuBuild[`PMFID_CSU_OFSR] = tOfsr & archExt;
        // (R4) monitor instance count
        csuBuild[`PMFID_CSU_NUM_LSB +: 16] = tNumMon;
    end

    // (R6) absent register reads zero
    assign csuWord = csuPresent ? csuBuild : 32'h00000000;

    // feature register low word
    reg [31:0] loBuild;
    always @* begin
        loBuild = 32'h00000000;
        // (R18) narrowing support
        loBuild[`PMFID_IDR_NRW] = hasNrw;
        // (R19) monitor presence
        loBuild[`PMFID_IDR_MSMON] = hasMsmon;
        // (R20) custom feature register presence
        loBuild[`PMFID_IDR_IMPL] = hasImpl;
        // (R21) upper half carries defined fields
        loBuild[`PMFID_IDR_EXT] = extLayout;
        // (R22) partitioning flags per instance
        loBuild[`PMFID_IDR_PART_LSB +: 4] = tPart;
        // (R23) group and partition maxima
        loBuild[`PMFID_IDR_PMG_LSB +: 8] = pmgMax;
        loBuild[`PMFID_IDR_PARTITION_IDENTIFIER_LSB +: 16] = partidMax;
    end

    assign idrLoWord = loBuild;

    // feature register high word
    reg [31:0] hiBuild;
    always @* begin
        hiBuild = 32'h00000000;
        // (R12) highest accepted instance number
        hiBuild[`PMFID_IDRH_RISMAX_LSB +: 4] = risMax;
        // (R13) error message-write flag
        hiBuild[`PMFID_IDRH_ERRMSI] = hasErrMsi;
        // (R14) error status and control present
        hiBuild[`PMFID_IDRH_ESR] = hasEsr;
        // (R15) error status width flag
        hiBuild[`PMFID_IDRH_EXTDESR] = wideEsr;
        // (R16) custom monitor and control absence
        hiBuild[`PMFID_IDRH_NOMON] = hasImpl & tNoMon;
        hiBuild[`PMFID_IDRH_NOCTL] = hasImpl & tNoCtl;
        // (R17) instance select flag
        hiBuild[`PMFID_IDRH_RIS] = hasRis;
    end

    // (R11) upper word exists only on extended architecture
    assign idrHiWord = extLayout ? hiBuild : 32'h00000000;

    // (R7) decode at the page offsets
    // (R8) same decode for both pages
    assign hitCsu = pageHit(addr, `PMFID_OFF_CSUMON);
    assign hitLo  = pageHit(addr, `PMFID_OFF_IDR_LO);
    assign hitHi  = pageHit(addr, `PMFID_OFF_IDR_HI);

    // read mux; unmapped offsets read as zero
    always @* begin
        rdData_nxt = 32'h00000000;
        ack_nxt    = rdReq | wrReq;
        if (rdReq) begin
            if (hitCsu) begin
                rdData_nxt = csuWord;
            end else if (hitLo) begin
                rdData_nxt = idrLoWord;
            end else if (hitHi) begin
                rdData_nxt = idrHiWord;
            end
        end
        // (R24) writes only acknowledged, nothing stored
    end

    // outputs straight from flops; data holds until the next request
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdData_r <= `PMFID_RST_DATA;
            ack_r    <= `PMFID_RST_ACK;
        end else begin
            ack_r <= ack_nxt;
            if (rdReq | wrReq) begin
                rdData_r <= rdData_nxt;
            end
        end
    end

endmodule

`default_nettype wire

// ==== verilog/pmfid_defines.vh ====
// constants for the partition/monitor feature identification registers
// assumes: included by bare name from the design files of this block
`ifndef PMFID_DEFINES_VH
`define PMFID_DEFINES_VH

// byte offsets inside one feature page (secure and non-secure alike)
`define PMFID_OFF_IDR_LO      12'h000
`define PMFID_OFF_IDR_HI      12'h004
`define PMFID_OFF_CSUMON      12'h088

// usage monitor capability register fields
`define PMFID_CSU_CAPTURE     31
`define PMFID_USAGE_COUNTER_READONLY_FLAG          30
`define PMFID_CSU_OFSR        26
`define PMFID_CSU_NUM_LSB     0

// feature register, low word
`define PMFID_IDR_NRW         31
`define PMFID_IDR_MSMON       30
`define PMFID_IDR_IMPL        29
`define PMFID_IDR_EXT         28
`define PMFID_IDR_PART_LSB    24
`define PMFID_IDR_PMG_LSB     16
`define PMFID_IDR_PARTITION_IDENTIFIER_LSB  0

// feature register, high word (bit n here is bit n+32)
`define PMFID_IDRH_RISMAX_LSB 24
`define PMFID_IDRH_ERRMSI     8
`define PMFID_IDRH_ESR        7
`define PMFID_IDRH_EXTDESR    6
`define PMFID_IDRH_NOMON      5
`define PMFID_IDRH_NOCTL      4
`define PMFID_IDRH_RIS        0

// implementation choices
`define PMFID_CFG_ARCH_EXT    1'b1
`define PMFID_CFG_EXT         1'b1
`define PMFID_CFG_RIS         1'b1
`define PMFID_CFG_HIGHEST_INSTANCE_NUMBER     4'h3
`define PMFID_CFG_ESR         1'b1
`define PMFID_CFG_ERRMSI      1'b1
`define PMFID_CFG_EXTDESR     1'b0
`define PMFID_CFG_IMPL        1'b1
`define PMFID_CFG_NRW         1'b0
`define PMFID_CFG_MSMON       1'b1
`define PMFID_CFG_CSU         1'b1
`define PMFID_CFG_PMG_NS      8'hff
`define PMFID_CFG_PARTITION_IDENTIFIER_NS   16'h003f
`define PMFID_CFG_PMG_S       8'h01
`define PMFID_CFG_PARTITION_IDENTIFIER_S    16'h000f

// per resource instance tables, entry n in bits of slot n
`define PMFID_TBL_CAPTURE     16'h000f
`define PMFID_TBL_CSURO       16'h000a
`define PMFID_TBL_OFSR        16'h0005
`define PMFID_TBL_NOMON       16'hffff
`define PMFID_TBL_NOCTL       16'hfffe
`define PMFID_TBL_PART        {16{4'hd}}
`define PMFID_TBL_NUM_NS      {16{16'h0010}}
`define PMFID_TBL_NUM_S       {16{16'h0004}}

// register port reset values
`define PMFID_RST_DATA        32'h00000000
`define PMFID_RST_ACK         1'b0

`endif

// ==== verilog/pmfid_inst_table.v ====
// per resource instance capability lookup
// assumes: instance index already forced to zero when selection is absent
`timescale 1ns/1ps
`default_nettype none
`include "pmfid_defines.vh"

module pmfid_inst_table (
    input  wire [3:0]  instSel,
    input  wire        secure,
    output wire        instValid,
    output wire        capture,
    output wire        csuRo,
    output wire        ofsr,
    output wire [15:0] numMon,
    output wire [3:0]  partFlags,
    output wire        noMon,
    output wire        noCtl
);

    wire [255:0] numNsTbl = `PMFID_TBL_NUM_NS;
    wire [255:0] numSTbl  = `PMFID_TBL_NUM_S;
    wire [63:0]  partTbl  = `PMFID_TBL_PART;
    wire [15:0]  numNsArr [0:15];
    wire [15:0]  numSArr  [0:15];
    wire [3:0]   partArr  [0:15];

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : slot
            assign numNsArr[g] = numNsTbl[g*16 +: 16];
            assign numSArr[g]  = numSTbl[g*16 +: 16];
            assign partArr[g]  = partTbl[g*4 +: 4];
        end
    endgenerate

    // instances beyond the highest number read as absent
    assign instValid = (instSel <= `PMFID_CFG_HIGHEST_INSTANCE_NUMBER);

    wire [15:0] capTbl = `PMFID_TBL_CAPTURE;
    wire [15:0] roTbl  = `PMFID_TBL_CSURO;
    wire [15:0] ofTbl  = `PMFID_TBL_OFSR;
    wire [15:0] nmTbl  = `PMFID_TBL_NOMON;
    wire [15:0] ncTbl  = `PMFID_TBL_NOCTL;

    assign capture   = instValid & capTbl[instSel];
    assign csuRo     = instValid & roTbl[instSel];
    assign ofsr      = instValid & ofTbl[instSel];
    assign noMon     = instValid & nmTbl[instSel];
    assign noCtl     = instValid & ncTbl[instSel];
    assign partFlags = instValid ? partArr[instSel] : 4'h0;
    assign numMon    = !instValid ? 16'h0000 :
                       (secure ? numSArr[instSel] : numNsArr[instSel]);

endmodule

`default_nettype wire

// ==== tb/pmfid_regs_checker.sv ====
// assertion checker for the feature identification register port
// assumes: bound to pmfid_regs built with the default constants
`timescale 1ns/1ps
`default_nettype none

module pmfid_regs_checker (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        rdReq,
    input wire logic        wrReq,
    input wire logic        secure,
    input wire logic [11:0] addr,
    input wire logic [3:0]  selInstance,
    input wire logic [31:0] rdData_r,
    input wire logic        ack_r
);
    wire req     = rdReq || wrReq;
    wire capHit  = rdReq && (addr[11:2] == 10'h022);
    wire inRange = selInstance < 4'h4;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_ack;
        req |=> ack_r;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_wrZero;
        (wrReq && !rdReq) |=> (rdData_r == 32'h0) && ack_r;
    endproperty
    a_wrZero: assert property (p_wrZero) else $error("write returned data");
    property p_hold;
        !req |=> $stable(rdData_r) && !ack_r;
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved while idle");
    property p_capRsvd;
        capHit |=> (rdData_r[29:27] == 3'h0) && (rdData_r[25:16] == 10'h0);
    endproperty
    a_capRsvd: assert property (p_capRsvd) else $error("reserved bits set");
    property p_cntNs;
        (capHit && inRange && !secure) |=> rdData_r[15:0] == 16'h0010;
    endproperty
    a_cntNs: assert property (p_cntNs) else $error("wrong count, open page");
    property p_cntS;
        (capHit && inRange && secure) |=> rdData_r[15:0] == 16'h0004;
    endproperty
    a_cntS: assert property (p_cntS) else $error("wrong count, secure page");
    property p_capRo;
        (capHit && inRange) |=> rdData_r[31] && (rdData_r[30] == $past(selInstance[0]));
    endproperty
    a_capRo: assert property (p_capRo) else $error("capture or ro flag wrong");
    property p_oor;
        (capHit && !inRange) |=> rdData_r == 32'h0;
    endproperty
    a_oor: assert property (p_oor) else $error("absent instance not zero");
    property p_low;
        (rdReq && addr[11:2] == 10'h000) |=> rdData_r[31:28] == 4'h7;
    endproperty
    a_low: assert property (p_low) else $error("low feature flags wrong");
    property p_high;
        (rdReq && addr[11:2] == 10'h001) |=> (rdData_r[27:24] == 4'h3) && rdData_r[0]
            && (rdData_r[8:6] == 3'h7) && (rdData_r[23:9] == 15'h0);
    endproperty
    a_high: assert property (p_high) else $error("high feature flags wrong");
endmodule

bind pmfid_regs pmfid_regs_checker i_pmfid_regs_checker (
    .clk_sys(clk_sys), .rst_b(rst_b), .rdReq(rdReq), .wrReq(wrReq), .secure(secure),
    .addr(addr), .selInstance(selInstance), .rdData_r(rdData_r), .ack_r(ack_r)
);

`default_nettype wire

// ==== tb/pmfid_regs_tb.sv ====
// self-checking bench for the feature identification registers
// assumes: default constants, answer exactly one cycle after a request
`timescale 1ns/1ps
`default_nettype none

module pmfid_regs_tb;
    logic        clk_sys;
    logic        rst_b;
    logic        rdReq;
    logic        wrReq;
    logic        secure;
    logic [11:0] addr;
    logic [3:0]  selInstance;
    wire  [31:0] rdData_r;
    wire         ack_r;
    logic [31:0] seed;
    logic [31:0] r;
    int          nFail;
    int          nTests;
    logic [11:0] adTbl [6] = '{12'h000, 12'h004, 12'h088, 12'h08b, 12'h08c, 12'hffc};

    pmfid_regs i_pmfid_regs (
        .clk_sys(clk_sys), .rst_b(rst_b), .rdReq(rdReq), .wrReq(wrReq), .secure(secure),
        .addr(addr), .selInstance(selInstance), .rdData_r(rdData_r), .ack_r(ack_r)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // instance fields vanish beyond the highest instance
    function automatic logic [31:0] expv(input logic sec, input logic [11:0] a,
                                         input logic [3:0] i);
        logic v;
        v = i < 4'h4;
        case (a[11:2])
            10'h000: return {4'h7, v ? 4'hd : 4'h0, sec ? 24'h01000f : 24'hff003f};
            10'h001: return {8'h03, 15'h0, 3'h7, v, v && (i != 4'h0), 3'h0, 1'b1};
            10'h022: return {v, v & i[0], 3'h0, v & ~i[0], 10'h0,
                             v ? (sec ? 16'h0004 : 16'h0010) : 16'h0000};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic rd, input logic wr, input logic sec,
                       input logic [11:0] a, input logic [3:0] i);
        rdReq = rd;
        wrReq = wr;
        secure = sec;
        addr = a;
        selInstance = i;
        @(posedge clk_sys);
        #1;
        chk({31'h0, ack_r}, 32'h1);
        chk(rdData_r, rd ? expv(sec, a, i) : 32'h0);
    endtask

    task automatic idle(input int n);
        rdReq = 1'b0;
        wrReq = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic endSim();
        if (nFail == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        nFail++;
        endSim();
    end

    initial begin : main
        logic [11:0] a;
        logic [3:0]  i;
        seed = 32'd68767;
        nFail = 0;
        nTests = 0;
        rst_b = 1'b0;
        rdReq = 1'b0;
        wrReq = 1'b0;
        secure = 1'b0;
        addr = 12'h000;
        selInstance = 4'h0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(rdData_r, 32'h0);
        chk({31'h0, ack_r}, 32'h0);
        rst_b = 1'b1;
        idle(1);
        // both pages, instances 0 to 4 and 15, back to back
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 6; k++) begin
                i = (k == 5) ? 4'hf : k[3:0];
                for (int j = 0; j < 6; j++) acc(1'b1, 1'b0, s[0], adTbl[j], i);
                acc(1'b0, 1'b1, s[0], 12'h000, i);
                acc(1'b0, 1'b1, s[0], 12'h088, i);
                acc(1'b1, 1'b1, s[0], 12'h088, i);
            end
        end
        acc(1'b1, 1'b0, 1'b0, 12'h088, 4'h1);
        selInstance = 4'h2;
        idle(3);
        chk(rdData_r, expv(1'b0, 12'h088, 4'h1));
        chk({31'h0, ack_r}, 32'h0);
        repeat (400) begin
            r = xs();
            case (r[1:0])
                2'd0: a = 12'h000;
                2'd1: a = 12'h004;
                2'd2: a = 12'h088;
                default: a = r[27:16];
            endcase
            acc(r[4] | ~r[5], r[5], r[10], {a[11:2], r[3:2]}, r[9:6]);
        end
        // reset in mid-run clears the port at once
        acc(1'b1, 1'b0, 1'b0, 12'h000, 4'h0);
        rst_b = 1'b0;
        #1;
        chk(rdData_r, 32'h0);
        chk({31'h0, ack_r}, 32'h0);
        idle(2);
        rst_b = 1'b1;
        idle(1);
        acc(1'b1, 1'b0, 1'b1, 12'h004, 4'h2);
        idle(1);
        endSim();
    end
endmodule

`default_nettype wire
